// >>> logic/cfg_defines.svh
// Shared constants for the configuration access channel: token codes,
// destination patterns, register numbers, reset values and write masks.
// Assumes inclusion by bare name from the device, requester and checker files.
`ifndef CFG_DEFINES_SVH
`define CFG_DEFINES_SVH

// Control token codes carried on the link.
`define CFG_TOK_WRITE 8'hC0
`define CFG_TOK_READ 8'hC1
`define CFG_TOK_END 8'h01
`define CFG_TOK_ACK 8'h03
`define CFG_TOK_NAK 8'h04

// Low half of the channel-end destination selecting a register space.
`define CFG_DEST_TILE 16'hC20C
`define CFG_DEST_NODE 16'hC30C

// Reply identifier low byte that suppresses the write reply.
`define CFG_NO_REPLY 8'hFF

// Registers held per configuration space.
`define CFG_NUM_REGS 16'h0008

// Processor status resource identifier: number shifted, tag in low byte.
`define CFG_PS_SHIFT 8
`define CFG_PS_TAG 8'h0B

// Processor status register numbers.
`define CFG_PS_RAM_BASE 8'h00
`define CFG_PS_VEC_BASE 8'h01
`define CFG_PS_TILE_CTRL 8'h02
`define CFG_PS_BOOT_STAT 8'h03
`define CFG_PS_DBG_BASE 8'h20
`define CFG_PS_DBG_COUNT 8'h08

// Reset values and writable-bit masks of the processor status registers.
`define CFG_RST_RAM_BASE 32'h0008_0000
`define CFG_RST_VEC_BASE 32'h0000_0000
`define CFG_RST_TILE_CTRL 32'h0000_1800
`define CFG_MSK_RAM_BASE 32'hFFFF_FFFC
`define CFG_MSK_VEC_BASE 32'hFFF8_0000
`define CFG_MSK_TILE_CTRL 32'h0000_1F11

`endif

// >>> logic/cfg_pkg.sv
// Types shared by both ends of the configuration access channel.
// Assumes cfg_defines.svh supplies the numeric constants.
package cfg_pkg;

  // Device end message handler states.
  typedef enum logic [3:0] {
    DS_HDR = 4'h0,
    DS_RID = 4'h1,
    DS_REG = 4'h2,
    DS_DAT = 4'h3,
    DS_END = 4'h4,
    DS_DRAIN = 4'h5,
    DS_EXEC = 4'h6,
    DS_RSP_HDR = 4'h7,
    DS_RSP_DAT = 4'h8,
    DS_RSP_END = 4'h9
  } dev_state_t;

  // Requester end states.
  typedef enum logic [2:0] {
    RS_IDLE = 3'h0,
    RS_SEND = 3'h1,
    RS_WAIT_HDR = 3'h2,
    RS_WAIT_DAT = 3'h3,
    RS_WAIT_END = 3'h4
  } req_state_t;

endpackage : cfg_pkg

// >>> logic/cfg_link_if.sv
// Token link between a requesting channel-end and the configuration end.
// Assumes both ends share one clock; each symbol is a control flag plus a
// byte, moved when valid and ready are both high on a clock edge.
interface cfg_link_if;
  logic req_valid;
  logic req_ctrl;
  logic [7:0] req_data;
  logic [31:0] req_dest;
  logic req_ready;
  logic rsp_valid;
  logic rsp_ctrl;
  logic [7:0] rsp_data;
  logic [23:0] rsp_dest;
  logic rsp_ready;

  modport device (
    input req_valid, req_ctrl, req_data, req_dest, rsp_ready,
    output req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
  );

  modport requester (
    output req_valid, req_ctrl, req_data, req_dest, rsp_ready,
    input req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
  );
endinterface : cfg_link_if

// >>> logic/cfg_device.sv
// Configuration end: decodes read and write messages for the tile and
// node register spaces and serves the local processor status port.
// Assumes one clock mclk and a requester that keeps the token framing.
`include "cfg_defines.svh"

// Operation
// (R1) Write: 192, reply id, register, data, 1
// (R2) Read: 193, reply id, register, 1
// (R3) Write reply: 3,1 success or 4,1 failure
// (R4) Read reply: 3, data word, 1, else 4,1
// (R5) Reply id low byte all ones: no reply (code suppresses only write replies; reads are still answered)
// (R6) Multi-byte fields travel most significant byte first
// (R7) Requester puts own channel-end upper bits in id
// (R8) Destination low half selects tile or node
// (R9) Status resource is number shifted eight, OR 0x0B
// (R10) Status registers reached by local word access
// (R11) Three separately numbered register spaces exist
// (R12) Debug registers act only in debug mode
// (R13) Unknown register or malformed message fails
// (R14) Finish request and reply before next one
module cfg_device (
  input wire logic mclk,
  input wire logic rst_b,
  cfg_link_if.device link,
  input wire logic debug_mode,
  input wire logic [31:0] boot_status,
  input wire logic ps_valid,
  input wire logic ps_write,
  input wire logic [15:0] ps_resource,
  input wire logic [31:0] ps_wdata,
  output logic ps_done,
  output logic ps_ok,
  output logic [31:0] ps_rdata,
  output logic [31:0] tile_ctrl
);

  cfg_pkg::dev_state_t state;
  cfg_pkg::dev_state_t next_state;
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic is_wr;
  logic next_is_wr;
  logic is_node;
  logic next_is_node;
  logic fail;
  logic next_fail;
  logic [23:0] rid;
  logic [23:0] next_rid;
  logic [15:0] regn;
  logic [15:0] next_regn;
  logic [31:0] wdata;
  logic [31:0] next_wdata;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic out_ctrl;
  logic next_out_ctrl;
  logic [7:0] out_data;
  logic [7:0] next_out_data;
  logic [31:0] tile_regs [0:7];
  logic [31:0] next_tile_regs [0:7];
  logic [31:0] node_regs [0:7];
  logic [31:0] next_node_regs [0:7];
  logic tok_end;
  logic reg_ok;

  // Only one message is in flight: intake stops while it runs and replies.
  assign link.req_ready = (state == cfg_pkg::DS_HDR) ||
    (state == cfg_pkg::DS_RID) || (state == cfg_pkg::DS_REG) ||
    (state == cfg_pkg::DS_DAT) || (state == cfg_pkg::DS_END) ||
    (state == cfg_pkg::DS_DRAIN); // [R14]
  assign link.rsp_valid = (state == cfg_pkg::DS_RSP_HDR) ||
    (state == cfg_pkg::DS_RSP_DAT) || (state == cfg_pkg::DS_RSP_END);
  assign link.rsp_ctrl = out_ctrl;
  assign link.rsp_data = out_data;
  assign link.rsp_dest = rid;
  assign tok_end = link.req_valid && link.req_ctrl &&
    (link.req_data == `CFG_TOK_END);
  assign reg_ok = !fail && (regn < `CFG_NUM_REGS); // [R13]

  // Message intake, register access and reply sequencing.
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_is_wr = is_wr;
    next_is_node = is_node;
    next_fail = fail;
    next_rid = rid;
    next_regn = regn;
    next_wdata = wdata;
    next_rdata = rdata;
    next_out_ctrl = out_ctrl;
    next_out_data = out_data;
    next_tile_regs = tile_regs;
    next_node_regs = node_regs;
    unique case (state)
      cfg_pkg::DS_HDR:
      begin
        // Without a reply id a stray symbol cannot be answered; drop it.
        if (link.req_valid && link.req_ctrl &&
            ((link.req_data == `CFG_TOK_WRITE) ||
             (link.req_data == `CFG_TOK_READ)))
        begin
          next_is_wr = (link.req_data == `CFG_TOK_WRITE); // [R1] [R2]
          next_cnt = 2'h0;
          next_state = cfg_pkg::DS_RID;
          next_is_node = (link.req_dest[15:0] == `CFG_DEST_NODE); // [R8]
          next_fail = (link.req_dest[15:0] != `CFG_DEST_NODE) &&
            (link.req_dest[15:0] != `CFG_DEST_TILE); // [R11]
        end
      end
      cfg_pkg::DS_RID, cfg_pkg::DS_REG, cfg_pkg::DS_DAT:
      begin
        if (link.req_valid && link.req_ctrl)
        begin
          // A control token inside a field is a framing fault.
          next_fail = 1'b1; // [R13]
          next_state = tok_end ? cfg_pkg::DS_EXEC : cfg_pkg::DS_DRAIN;
        end
        else if (link.req_valid)
        begin
          next_cnt = cnt + 2'h1;
          if (state == cfg_pkg::DS_RID)
          begin
            next_rid = {rid[15:0], link.req_data}; // [R6] [R7]
            if (cnt == 2'h2)
            begin
              next_cnt = 2'h0;
              next_state = cfg_pkg::DS_REG;
            end
          end
          else if (state == cfg_pkg::DS_REG)
          begin
            next_regn = {regn[7:0], link.req_data}; // [R6]
            if (cnt == 2'h1)
            begin
              next_cnt = 2'h0;
              next_state = is_wr ? cfg_pkg::DS_DAT : cfg_pkg::DS_END;
            end
          end
          else
          begin
            next_wdata = {wdata[23:0], link.req_data}; // [R6]
            if (cnt == 2'h3)
              next_state = cfg_pkg::DS_END;
          end
        end
      end
      cfg_pkg::DS_END:
      begin
        if (tok_end)
          next_state = cfg_pkg::DS_EXEC;
        else if (link.req_valid)
        begin
          next_fail = 1'b1; // [R13]
          next_state = cfg_pkg::DS_DRAIN;
        end
      end
      cfg_pkg::DS_DRAIN:
      begin
        if (tok_end)
          next_state = cfg_pkg::DS_EXEC;
      end
      cfg_pkg::DS_EXEC:
      begin
        next_fail = !reg_ok;
        next_rdata = 32'h0000_0000;
        if (reg_ok && is_wr && is_node)
          next_node_regs[regn[2:0]] = wdata;
        else if (reg_ok && is_wr)
          next_tile_regs[regn[2:0]] = wdata;
        else if (reg_ok)
          next_rdata = is_node ? node_regs[regn[2:0]] :
            tile_regs[regn[2:0]];
        next_out_ctrl = 1'b1;
        next_out_data = reg_ok ? `CFG_TOK_ACK : `CFG_TOK_NAK; // [R3] [R4]
        next_cnt = 2'h0;
        if (is_wr && (rid[7:0] == `CFG_NO_REPLY))
          next_state = cfg_pkg::DS_HDR; // [R5]
        else
          next_state = cfg_pkg::DS_RSP_HDR;
      end
      cfg_pkg::DS_RSP_HDR:
      begin
        if (link.rsp_ready && !fail && !is_wr)
        begin
          next_out_ctrl = 1'b0;
          next_out_data = rdata[31:24]; // [R4] [R6]
          next_rdata = {rdata[23:0], 8'h00};
          next_state = cfg_pkg::DS_RSP_DAT;
        end
        else if (link.rsp_ready)
        begin
          next_out_data = `CFG_TOK_END; // [R3]
          next_state = cfg_pkg::DS_RSP_END;
        end
      end
      cfg_pkg::DS_RSP_DAT:
      begin
        if (link.rsp_ready)
        begin
          next_cnt = cnt + 2'h1;
          next_out_data = rdata[31:24]; // [R6]
          next_rdata = {rdata[23:0], 8'h00};
          if (cnt == 2'h3)
          begin
            next_out_ctrl = 1'b1;
            next_out_data = `CFG_TOK_END; // [R4]
            next_state = cfg_pkg::DS_RSP_END;
          end
        end
      end
      cfg_pkg::DS_RSP_END:
      begin
        if (link.rsp_ready)
          next_state = cfg_pkg::DS_HDR; // [R14]
      end
      default:
        next_state = cfg_pkg::DS_HDR;
    endcase
  end

  // Message handler registers.
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      state <= cfg_pkg::DS_HDR;
      cnt <= 2'h0;
      is_wr <= 1'b0;
      is_node <= 1'b0;
      fail <= 1'b0;
      rid <= 24'h00_0000;
      regn <= 16'h0000;
      wdata <= 32'h0000_0000;
      rdata <= 32'h0000_0000;
      out_ctrl <= 1'b0;
      out_data <= 8'h00;
      for (int i = 0; i < 8; i++)
      begin
        tile_regs[i] <= 32'h0000_0000;
        node_regs[i] <= 32'h0000_0000;
      end
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      is_wr <= next_is_wr;
      is_node <= next_is_node;
      fail <= next_fail;
      rid <= next_rid;
      regn <= next_regn;
      wdata <= next_wdata;
      rdata <= next_rdata;
      out_ctrl <= next_out_ctrl;
      out_data <= next_out_data;
      tile_regs <= next_tile_regs;
      node_regs <= next_node_regs;
    end
  end

  // Local processor status access; never reached over the link.
  logic [31:0] ps_regs [0:2];
  logic [31:0] next_ps_regs [0:2];
  logic [31:0] dbg_regs [0:7];
  logic [31:0] next_dbg_regs [0:7];
  logic next_ps_done;
  logic next_ps_ok;
  logic [31:0] next_ps_rdata;
  logic [7:0] ps_num;
  logic [7:0] dbg_idx;
  logic ps_tag_ok;
  logic ps_is_dbg;
  logic [31:0] ps_mask;

  assign ps_num = ps_resource[15:`CFG_PS_SHIFT]; // [R9]
  assign ps_tag_ok = (ps_resource[7:0] == `CFG_PS_TAG); // [R9]
  assign dbg_idx = ps_num - `CFG_PS_DBG_BASE;
  assign ps_is_dbg = (ps_num >= `CFG_PS_DBG_BASE) &&
    (dbg_idx < `CFG_PS_DBG_COUNT);
  assign ps_mask = (ps_num == `CFG_PS_RAM_BASE) ? `CFG_MSK_RAM_BASE :
    (ps_num == `CFG_PS_VEC_BASE) ? `CFG_MSK_VEC_BASE : `CFG_MSK_TILE_CTRL;
  assign tile_ctrl = ps_regs[2];

  // Read-only bits keep their value through a masked merge on write.
  always_comb
  begin
    next_ps_regs = ps_regs;
    next_dbg_regs = dbg_regs;
    next_ps_done = ps_valid; // [R10]
    next_ps_ok = 1'b0;
    next_ps_rdata = 32'h0000_0000;
    if (ps_valid && ps_tag_ok && (ps_num <= `CFG_PS_TILE_CTRL))
    begin
      next_ps_ok = 1'b1;
      next_ps_rdata = ps_regs[ps_num[1:0]];
      if (ps_write)
        next_ps_regs[ps_num[1:0]] = (ps_regs[ps_num[1:0]] & ~ps_mask) |
          (ps_wdata & ps_mask); // [R12]
    end
    else if (ps_valid && ps_tag_ok && (ps_num == `CFG_PS_BOOT_STAT))
    begin
      next_ps_ok = 1'b1;
      next_ps_rdata = boot_status; // [R12]
    end
    else if (ps_valid && ps_tag_ok && ps_is_dbg && debug_mode)
    begin
      next_ps_ok = 1'b1;
      next_ps_rdata = dbg_regs[dbg_idx[2:0]];
      if (ps_write)
        next_dbg_regs[dbg_idx[2:0]] = ps_wdata; // [R12]
    end
  end

  // Processor status registers and the access result.
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      ps_regs[0] <= `CFG_RST_RAM_BASE;
      ps_regs[1] <= `CFG_RST_VEC_BASE;
      ps_regs[2] <= `CFG_RST_TILE_CTRL;
      for (int i = 0; i < 8; i++)
        dbg_regs[i] <= 32'h0000_0000;
      ps_done <= 1'b0;
      ps_ok <= 1'b0;
      ps_rdata <= 32'h0000_0000;
    end
    else
    begin
      ps_regs <= next_ps_regs;
      dbg_regs <= next_dbg_regs;
      ps_done <= next_ps_done;
      ps_ok <= next_ps_ok;
      ps_rdata <= next_ps_rdata;
    end
  end

endmodule : cfg_device

// >>> logic/cfg_requester.sv
// Requesting channel-end: turns one user command into a read or write
// message and collects the reply.
// Assumes one clock mclk shared with the configuration end.
`include "cfg_defines.svh"

module cfg_requester (
  input wire logic mclk,
  input wire logic rst_b,
  cfg_link_if.requester link,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_node,
  input wire logic [15:0] cmd_target,
  input wire logic [23:0] cmd_rid,
  input wire logic [15:0] cmd_reg,
  input wire logic [31:0] cmd_wdata,
  output logic cmd_ready,
  output logic done,
  output logic done_ok,
  output logic [31:0] done_rdata
);

  cfg_pkg::req_state_t state;
  cfg_pkg::req_state_t next_state;
  logic [3:0] k;
  logic [3:0] next_k;
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic wr;
  logic next_wr;
  logic [23:0] rid;
  logic [23:0] next_rid;
  logic [15:0] regn;
  logic [15:0] next_regn;
  logic [31:0] wdata;
  logic [31:0] next_wdata;
  logic [31:0] dest;
  logic [31:0] next_dest;
  logic [8:0] sym;
  logic [8:0] next_sym;
  logic next_done;
  logic next_done_ok;
  logic [31:0] next_done_rdata;
  logic [3:0] last_k;

  // Symbol k of a message as {control flag, byte}, high bytes first.
  function automatic logic [8:0] sym_at(
    input logic [3:0] idx,
    input logic w,
    input logic [23:0] r,
    input logic [15:0] n,
    input logic [31:0] d
  );
    logic [8:0] s;
    s = {1'b1, `CFG_TOK_END};
    unique case (idx)
      4'h0: s = {1'b1, w ? `CFG_TOK_WRITE : `CFG_TOK_READ}; // [R1] [R2]
      4'h1: s = {1'b0, r[23:16]}; // [R6] [R7]
      4'h2: s = {1'b0, r[15:8]};
      4'h3: s = {1'b0, r[7:0]};
      4'h4: s = {1'b0, n[15:8]};
      4'h5: s = {1'b0, n[7:0]};
      4'h6: s = w ? {1'b0, d[31:24]} : {1'b1, `CFG_TOK_END};
      4'h7: s = {1'b0, d[23:16]};
      4'h8: s = {1'b0, d[15:8]};
      4'h9: s = {1'b0, d[7:0]};
      default: s = {1'b1, `CFG_TOK_END};
    endcase
    return s;
  endfunction : sym_at

  assign last_k = wr ? 4'hA : 4'h6;
  assign cmd_ready = (state == cfg_pkg::RS_IDLE);
  assign link.req_valid = (state == cfg_pkg::RS_SEND);
  assign link.req_ctrl = sym[8];
  assign link.req_data = sym[7:0];
  assign link.req_dest = dest;
  assign link.rsp_ready = (state == cfg_pkg::RS_WAIT_HDR) ||
    (state == cfg_pkg::RS_WAIT_DAT) || (state == cfg_pkg::RS_WAIT_END);

  // Send the message symbol by symbol, then wait for its reply.
  always_comb
  begin
    next_state = state;
    next_k = k;
    next_cnt = cnt;
    next_wr = wr;
    next_rid = rid;
    next_regn = regn;
    next_wdata = wdata;
    next_dest = dest;
    next_sym = sym;
    next_done = 1'b0;
    next_done_ok = done_ok;
    next_done_rdata = done_rdata;
    unique case (state)
      cfg_pkg::RS_IDLE:
      begin
        if (cmd_valid)
        begin
          next_wr = cmd_write;
          next_rid = cmd_rid; // [R7]
          next_regn = cmd_reg;
          next_wdata = cmd_wdata;
          next_dest = {cmd_target,
            cmd_node ? `CFG_DEST_NODE : `CFG_DEST_TILE}; // [R8]
          next_sym = sym_at(4'h0, cmd_write, cmd_rid, cmd_reg, cmd_wdata);
          next_k = 4'h1;
          next_state = cfg_pkg::RS_SEND;
        end
      end
      cfg_pkg::RS_SEND:
      begin
        if (link.req_ready && (k == last_k + 4'h1))
        begin
          // A write with the suppress pattern gets no reply to wait for.
          if (wr && (rid[7:0] == `CFG_NO_REPLY)) // [R5]
          begin
            next_done = 1'b1;
            next_done_ok = 1'b1;
            next_state = cfg_pkg::RS_IDLE;
          end
          else
            next_state = cfg_pkg::RS_WAIT_HDR;
        end
        else if (link.req_ready)
        begin
          next_sym = sym_at(k, wr, rid, regn, wdata);
          next_k = k + 4'h1;
        end
      end
      cfg_pkg::RS_WAIT_HDR:
      begin
        if (link.rsp_valid)
        begin
          next_done_ok = link.rsp_ctrl && (link.rsp_data == `CFG_TOK_ACK);
          next_cnt = 2'h0;
          next_state = (next_done_ok && !wr) ? cfg_pkg::RS_WAIT_DAT :
            cfg_pkg::RS_WAIT_END; // [R3] [R4]
        end
      end
      cfg_pkg::RS_WAIT_DAT:
      begin
        if (link.rsp_valid && link.rsp_ctrl)
        begin
          next_done_ok = 1'b0;
          next_done = (link.rsp_data == `CFG_TOK_END);
          next_state = next_done ? cfg_pkg::RS_IDLE : cfg_pkg::RS_WAIT_END;
        end
        else if (link.rsp_valid)
        begin
          next_done_rdata = {done_rdata[23:0], link.rsp_data}; // [R6]
          next_cnt = cnt + 2'h1;
          if (cnt == 2'h3)
            next_state = cfg_pkg::RS_WAIT_END;
        end
      end
      cfg_pkg::RS_WAIT_END:
      begin
        if (link.rsp_valid && link.rsp_ctrl &&
            (link.rsp_data == `CFG_TOK_END))
        begin
          next_done = 1'b1;
          next_state = cfg_pkg::RS_IDLE;
        end
      end
      default:
        next_state = cfg_pkg::RS_IDLE;
    endcase
  end

  // Requester registers.
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      state <= cfg_pkg::RS_IDLE;
      k <= 4'h0;
      cnt <= 2'h0;
      wr <= 1'b0;
      rid <= 24'h00_0000;
      regn <= 16'h0000;
      wdata <= 32'h0000_0000;
      dest <= 32'h0000_0000;
      sym <= 9'h000;
      done <= 1'b0;
      done_ok <= 1'b0;
      done_rdata <= 32'h0000_0000;
    end
    else
    begin
      state <= next_state;
      k <= next_k;
      cnt <= next_cnt;
      wr <= next_wr;
      rid <= next_rid;
      regn <= next_regn;
      wdata <= next_wdata;
      dest <= next_dest;
      sym <= next_sym;
      done <= next_done;
      done_ok <= next_done_ok;
      done_rdata <= next_done_rdata;
    end
  end

endmodule : cfg_requester

// >>> dv/cfg_link_assertions.sv
// Checker of the token link between requester and configuration end.
// Assumes instantiation beside the interface, fed with its plain signals.
`include "cfg_defines.svh"
module cfg_link_assertions (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic req_ctrl,
  input wire logic [7:0] req_data,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic rsp_ctrl,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req_take;
  logic rsp_take;
  logic end_take;
  logic rsp_end;
  logic [3:0] req_cnt;
  logic [2:0] rsp_cnt;
  logic is_wr;
  logic no_rsp;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // Symbols moved this cycle; end tokens close a message or a reply.
  assign req_take = req_valid && req_ready;
  assign rsp_take = rsp_valid && rsp_ready;
  assign end_take = req_take && req_ctrl && req_data == `CFG_TOK_END;
  assign rsp_end = rsp_take && rsp_ctrl && rsp_data == `CFG_TOK_END;

  // Field counts are kept so lengths can be judged only at the end token.
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      req_cnt <= 4'h0;
      rsp_cnt <= 3'h0;
      is_wr <= 1'b0;
      no_rsp <= 1'b0;
    end
    else
    begin
      if (req_take && req_ctrl && req_data != `CFG_TOK_END)
      begin
        req_cnt <= 4'h0;
        is_wr <= req_data == `CFG_TOK_WRITE;
        no_rsp <= 1'b0;
      end
      else if (req_take && !req_ctrl)
      begin
        req_cnt <= req_cnt + 4'h1;
        if (req_cnt == 4'h2 && req_data == `CFG_NO_REPLY)
          no_rsp <= 1'b1;
      end
      if (rsp_take && rsp_ctrl && rsp_data != `CFG_TOK_END)
        rsp_cnt <= 3'h0;
      else if (rsp_take && !rsp_ctrl)
        rsp_cnt <= rsp_cnt + 3'h1;
    end
  end

  chk_busy_refuse:
    assert property (rsp_valid |-> !req_ready)
    else $error("request accepted during a reply");
  chk_reply_head:
    assert property ($rose(rsp_valid) |-> rsp_ctrl &&
      (rsp_data == `CFG_TOK_ACK || rsp_data == `CFG_TOK_NAK))
    else $error("reply does not open with token 3 or 4");
  chk_nak_end:
    assert property (rsp_take && rsp_ctrl && rsp_data == `CFG_TOK_NAK
      |=> rsp_valid && rsp_ctrl && rsp_data == `CFG_TOK_END)
    else $error("failure token not followed by token 1");
  chk_req_length:
    assert property (end_take |-> req_cnt == (is_wr ? 4'h9 : 4'h5))
    else $error("request has wrong number of field bytes");
  chk_read_len:
    assert property (rsp_end |-> rsp_cnt == 3'h0 || rsp_cnt == 3'h4)
    else $error("reply data is not one whole word");
  chk_reply_time:
    assert property (end_take && !(is_wr && no_rsp)
      |=> !req_ready ##1 rsp_valid)
    else $error("reply did not start two cycles after end token");
  chk_no_reply:
    assert property (end_take && is_wr && no_rsp
      |=> !rsp_valid ##1 (req_ready && !rsp_valid))
    else $error("suppressed write still answered");
  chk_ready_return:
    assert property (rsp_end |-> ##[1:2] req_ready)
    else $error("device not ready after its reply");

  cover property (end_take && is_wr && no_rsp);
  cover property (rsp_take && rsp_ctrl && rsp_data == `CFG_TOK_NAK);
  cover property (rsp_end && rsp_cnt == 3'h4);
endmodule : cfg_link_assertions

// >>> dv/config_register_access_protocol_tb.sv
// Bench joining requester and configuration end over the token link.
// Assumes the design files and the checker are compiled before it.
module config_register_access_protocol_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_b, debug_mode, ps_valid, ps_write, ps_done, ps_ok;
  logic [31:0] boot_status, ps_wdata, ps_rdata, tile_ctrl;
  logic [31:0] cmd_wdata, done_rdata, seen_dest;
  logic [15:0] ps_resource, cmd_target, cmd_reg;
  logic [23:0] cmd_rid, seen_rid;
  logic cmd_valid, cmd_write, cmd_node, cmd_ready, done, done_ok;
  logic [8:0] seen_q[$];
  logic [8:0] wire_exp [11] = '{9'h1C0, 9'h012, 9'h034, 9'h000, 9'h000,
    9'h002, 9'h0A5, 9'h0C3, 9'h01E, 9'h077, 9'h101};
  int num_errors, compares, cycles;

  cfg_link_if link ();
  cfg_device i_cfg_device (.mclk(mclk), .rst_b(rst_b), .link(link),
    .debug_mode(debug_mode), .boot_status(boot_status),
    .ps_valid(ps_valid), .ps_write(ps_write), .ps_resource(ps_resource),
    .ps_wdata(ps_wdata), .ps_done(ps_done), .ps_ok(ps_ok),
    .ps_rdata(ps_rdata), .tile_ctrl(tile_ctrl));
  cfg_requester i_cfg_requester (.mclk(mclk), .rst_b(rst_b), .link(link),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_node(cmd_node),
    .cmd_target(cmd_target), .cmd_rid(cmd_rid), .cmd_reg(cmd_reg),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .done(done),
    .done_ok(done_ok), .done_rdata(done_rdata));
  cfg_link_assertions i_cfg_link_assertions (.mclk(mclk), .rst_b(rst_b),
    .req_valid(link.req_valid), .req_ctrl(link.req_ctrl),
    .req_data(link.req_data), .req_ready(link.req_ready),
    .rsp_valid(link.rsp_valid), .rsp_ctrl(link.rsp_ctrl),
    .rsp_data(link.rsp_data), .rsp_ready(link.rsp_ready));

  // The 40 MHz clock.
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Records every request symbol taken and cuts a hang short.
  always @(posedge mclk)
  begin
    if (link.req_valid && link.req_ready)
    begin
      seen_q.push_back({link.req_ctrl, link.req_data});
      seen_dest = link.req_dest;
    end
    // The reply destination is kept so each answered command can check it.
    if (link.rsp_valid && link.rsp_ready)
      seen_rid = link.rsp_dest;
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  task check(input string name, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  // One link command; waits are bounded so a stuck end cannot hang here.
  task cmd(input logic w, n, input logic [15:0] r, input logic [23:0] id,
    input logic [31:0] d, input logic ok, input logic [31:0] rd);
    int i;
    for (i = 0; i < 100 && cmd_ready !== 1'b1; i++)
    begin
      @(posedge mclk);
      #1;
    end
    check("cmd_ready", {31'h0, cmd_ready}, 32'h1);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_node = n;
    cmd_target = n ? 16'h0009 : 16'h0005;
    cmd_reg = r;
    cmd_rid = id;
    cmd_wdata = d;
    @(posedge mclk);
    #1 cmd_valid = 1'b0;
    for (i = 0; i < 100 && done !== 1'b1; i++)
    begin
      @(posedge mclk);
      #1;
    end
    check("done", {31'h0, done}, 32'h1);
    check("done_ok", {31'h0, done_ok}, {31'h0, ok});
    // A suppressed write has no reply, so there is no destination to check.
    if (!(w && id[7:0] == 8'hFF))
      check("rsp_dest", {8'h0, seen_rid}, {8'h0, id});
    if (!w && ok)
      check("done_rdata", done_rdata, rd);
  endtask : cmd

  // One status word access; the trailing edge keeps pulses apart.
  task ps(input logic w, input logic [15:0] res, input logic [31:0] d,
    input logic ok, input logic [31:0] rd);
    ps_valid = 1'b1;
    ps_write = w;
    ps_resource = res;
    ps_wdata = d;
    @(posedge mclk);
    #1 ps_valid = 1'b0;
    check("ps_done", {31'h0, ps_done}, 32'h1);
    check("ps_ok", {31'h0, ps_ok}, {31'h0, ok});
    if (!w && ok)
      check("ps_rdata", ps_rdata, rd);
    @(posedge mclk);
    #1;
  endtask : ps

  task print_verdict();
    $display("compares %0d, num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  // Main sequence: link traffic to both spaces, then the status port.
  initial
  begin
    {rst_b, debug_mode, ps_valid, ps_write, cmd_valid, cmd_write} = 6'h0;
    {cmd_node, ps_resource, ps_wdata, cmd_target, cmd_reg} = 81'h0;
    {cmd_rid, cmd_wdata} = 56'h0;
    boot_status = 32'h0012_0105;
    repeat (4) @(posedge mclk);
    #1 rst_b = 1'b1;
    check("tile_ctrl", tile_ctrl, 32'h0000_1800);
    seen_q.delete();
    cmd(1, 0, 16'h0002, 24'h123400, 32'hA5C3_1E77, 1, 0);
    for (int k = 0; k < 11; k++)
      check("req_symbol", {23'h0, seen_q[k]}, {23'h0, wire_exp[k]});
    check("req_dest", seen_dest, 32'h0005_C20C);
    cmd(0, 0, 16'h0002, 24'h123400, 0, 1, 32'hA5C3_1E77);
    cmd(1, 1, 16'h0002, 24'h123400, 32'h0F0F_1234, 1, 0);
    cmd(0, 1, 16'h0002, 24'h123400, 0, 1, 32'h0F0F_1234);
    cmd(0, 0, 16'h0002, 24'h123400, 0, 1, 32'hA5C3_1E77);
    cmd(1, 0, 16'h0007, 24'h1234FF, 32'hDEAD_BEEF, 1, 0);
    cmd(0, 0, 16'h0007, 24'h123400, 0, 1, 32'hDEAD_BEEF);
    cmd(0, 0, 16'h0008, 24'h123400, 0, 0, 0);
    cmd(1, 1, 16'h0100, 24'h123400, 32'h1, 0, 0);
    ps(0, 16'h000B, 0, 1, 32'h0008_0000);
    ps(1, 16'h020B, 32'hFFFF_FFFF, 1, 0);
    check("tile_ctrl", tile_ctrl, 32'h0000_1F11);
    ps(1, 16'h030B, 32'h0, 1, 0);
    ps(0, 16'h030B, 0, 1, 32'h0012_0105);
    ps(1, 16'h200B, 32'h55, 0, 0);
    debug_mode = 1'b1;
    ps(0, 16'h200B, 0, 1, 32'h0);
    ps(1, 16'h200B, 32'h55, 1, 0);
    ps(0, 16'h200B, 0, 1, 32'h55);
    ps(0, 16'h000C, 0, 0, 0);
    print_verdict();
  end
endmodule : config_register_access_protocol_tb
